// File: verilog/nco_output_stage.sv
`default_nettype none
// What this block does
// - fdc mode toggles output each overflow
// - fdc chosen when mode select clear
// - pf mode outputs pulse, then inactive
// - output pulse starts two clock edges after accumulator_wrap
// - pf chosen when mode select set
// - width select sets pulse length
// - too-wide pulse means no new toggle
// - polarity bit is final output stage
// - polarity change raises interrupt when enabled
// - output fans out to five consumers
// - overflow sets interrupt flag
// - request needs all four enables
// - reset clears all registers to zero
// - runs in sleep on own clock
// - keep fast oscillator on in sleep
module nco_output_stage
  import nco_out_pkg::*;
#(
  parameter int unsigned ACC_WIDTH = ACC_WIDTH_DEF
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // configuration
  input  wire nco_out_pkg::osc_ctrl_t ctrl,
  input  wire logic [ACC_WIDTH-1:0]   increment,
  input  wire nco_out_pkg::irq_enables_t irq_en,
  input  wire logic                   fast_osc_selected,
  input  wire logic                   sleep_req,
  // software clear of the overflow flag
  input  wire logic                   flag_clear,
  // status
  output logic [ACC_WIDTH-1:0]        accumulator,
  output logic                        accumulator_wrap,
  output logic                        overflow_irq_flag,
  output logic                        irq_request,
  output logic                        keep_fast_osc_on,
  // outputs
  output logic                        synth_output,
  output nco_out_pkg::consumer_taps_t taps
);
  out_mode_t           mode;
  logic [ACC_WIDTH:0]  next_sum;
  logic                toggle_state;
  logic                pulse_state;
  logic                raw_level;
  logic                next_out;
  logic                pol_q;
  logic                pol_event;

  initial begin
    if (ACC_WIDTH < 2 || ACC_WIDTH > 32) $error("nco_output_stage: ACC_WIDTH out of range");
  end

  assign mode     = ctrl.pulse_freq_mode_select ? pulse_frequency_mode : fixed_duty_mode;
  assign next_sum = {1'b0, accumulator} + {1'b0, increment};

  // accumulate and flag carry-out; clk_sys is the module's own clock, so sleep of the cpu does not stop it
  // independent clocking
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !ctrl.module_enable_bit) begin
      accumulator      <= '0;
      accumulator_wrap <= LEVEL_LO;
    end else begin
      accumulator      <= next_sum[ACC_WIDTH-1:0];
      accumulator_wrap <= next_sum[ACC_WIDTH];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !ctrl.module_enable_bit) begin
      toggle_state <= LEVEL_LO;
    end else if (mode == fixed_duty_mode && accumulator_wrap) begin
      toggle_state <= ~toggle_state;
    end
  end

  pulse_shaper #(
    .PW_BITS (PWS_WIDTH)
  ) u_pulse (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .active_mode (ctrl.module_enable_bit && mode == pulse_frequency_mode),
    .width_sel   (ctrl.pulse_width_select),
    .trigger     (accumulator_wrap),
    .pulse       (pulse_state)
  );

  always_comb begin
    case (mode)
      fixed_duty_mode:      raw_level = toggle_state;
      pulse_frequency_mode: raw_level = pulse_state;
      default:              raw_level = LEVEL_LO;
    endcase
  end

  assign next_out = raw_level ^ ctrl.output_polarity_bit;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      synth_output <= LEVEL_LO;
      taps         <= '0;
    end else begin
      synth_output <= next_out;
      taps         <= {5{next_out}};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pol_q <= LEVEL_LO;
    end else begin
      pol_q <= ctrl.output_polarity_bit;
    end
  end
  assign pol_event = (pol_q != ctrl.output_polarity_bit) && irq_en.overflow_irq_enable
                     && ctrl.module_enable_bit;

  // set wins over a clear in the same cycle
  // flag set
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overflow_irq_flag <= LEVEL_LO;
    end else if (accumulator_wrap || pol_event) begin
      overflow_irq_flag <= 1'b1;
    end else if (flag_clear) begin
      overflow_irq_flag <= LEVEL_LO;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_request <= LEVEL_LO;
    end else begin
      irq_request <= overflow_irq_flag && ctrl.module_enable_bit && irq_en.overflow_irq_enable
                     && irq_en.peripheral_irq_enable && irq_en.global_irq_enable;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      keep_fast_osc_on <= LEVEL_LO;
    end else begin
      keep_fast_osc_on <= sleep_req && ctrl.module_enable_bit && fast_osc_selected;
    end
  end
endmodule : nco_output_stage
`default_nettype wire

// File: verilog/nco_out_pkg.sv
`default_nettype none
package nco_out_pkg;
  localparam int unsigned ACC_WIDTH_DEF = 20;
  localparam int unsigned PWS_WIDTH     = 3;
  localparam int unsigned CLK_HZ        = 20_000_000;

  // software-side controls of the oscillator
  typedef struct packed {
    logic                 module_enable_bit;
    logic                 pulse_freq_mode_select;
    logic                 output_polarity_bit;
    logic [PWS_WIDTH-1:0] pulse_width_select;
  } osc_ctrl_t;

  // interrupt enables along the request path
  typedef struct packed {
    logic overflow_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
  } irq_enables_t;

  // copies of the final output for each consumer
  typedef struct packed {
    logic logic_cell;
    logic waveform_generator;
    logic timer_one;
    logic timer_two;
    logic reference_clock_out;
  } consumer_taps_t;

  typedef enum logic {
    fixed_duty_mode,
    pulse_frequency_mode
  } out_mode_t;

  localparam logic [PWS_WIDTH-1:0] PWS_ZERO = 3'h0;
  localparam logic                 LEVEL_LO = 1'b0;
endpackage : nco_out_pkg
`default_nettype wire

// File: verilog/pulse_shaper.sv
`default_nettype none
module pulse_shaper
  import nco_out_pkg::*;
#(
  parameter int unsigned PW_BITS = PWS_WIDTH
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // control
  input  wire logic               active_mode,
  input  wire logic [PW_BITS-1:0] width_sel,
  input  wire logic               trigger,
  // state
  output logic                    pulse
);
  // pulse lasts 2**width_sel module clock periods
  localparam int unsigned CNT_BITS = (1 << PW_BITS) + 1;

  logic [CNT_BITS-1:0] remain;
  logic [CNT_BITS-1:0] width_cycles;

  initial begin
    if (PW_BITS < 1 || PW_BITS > 4) $error("pulse_shaper: PW_BITS out of range");
  end

  assign width_cycles = CNT_BITS'(1) << width_sel;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !active_mode) begin
      remain <= '0;
      pulse  <= LEVEL_LO;
    end else if (trigger && remain == '0) begin
      // a trigger during a running pulse is ignored: no toggle
      remain <= width_cycles - CNT_BITS'(1);
      pulse  <= 1'b1;
    end else if (remain != '0) begin
      remain <= remain - CNT_BITS'(1);
    end else begin
      pulse <= LEVEL_LO;
    end
  end
endmodule : pulse_shaper
`default_nettype wire

// File: dv/consumer_model.sv
`default_nettype none
module consumer_model (
  // consumer side
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        tap,
  output logic [15:0]      rises
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  // a timer input only sees rising edges, so that is all we count
  always_ff @(posedge clk_sys) begin
    prev <= tap;
    if (!rst_n) rises <= 16'h0;
    else if (tap && !prev) rises <= rises + 16'h1;
  end
endmodule : consumer_model
`default_nettype wire

// File: dv/nco_output_stage_props.sv
`default_nettype none
module out_props
  import nco_out_pkg::*;
#(parameter int unsigned ACC_WIDTH = ACC_WIDTH_DEF) (
  // watched ports
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire nco_out_pkg::osc_ctrl_t      ctrl,
  input wire logic [ACC_WIDTH-1:0]        increment,
  input wire nco_out_pkg::irq_enables_t   irq_en,
  input wire logic                        flag_clear,
  input wire logic [ACC_WIDTH-1:0]        accumulator,
  input wire logic                        accumulator_wrap,
  input wire logic                        overflow_irq_flag,
  input wire logic                        irq_request,
  input wire logic                        synth_output,
  input wire nco_out_pkg::consumer_taps_t taps
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pf, en, act, all_en;
  logic [7:0] run;
  assign pf = ctrl.pulse_freq_mode_select;
  assign en = ctrl.module_enable_bit;
  assign act = synth_output ^ ctrl.output_polarity_bit;
  assign all_en = overflow_irq_flag && en && (&irq_en);
  // length of the current active stretch
  always_ff @(posedge clk_sys) run <= act ? run + 8'h1 : 8'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_sum; en |=> {accumulator_wrap, accumulator} == {1'b0, $past(accumulator)} + $past(increment); endproperty
  a_sum: assert property (p_sum) else $error("bad sum or carry");
  property p_set; accumulator_wrap |=> overflow_irq_flag; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_hold; overflow_irq_flag && !flag_clear |=> overflow_irq_flag; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_irq; 1 |=> irq_request == $past(all_en); endproperty
  a_irq: assert property (p_irq) else $error("bad request");
  property p_tog; !pf && en && accumulator_wrap ##1 !pf && en |=> synth_output != $past(synth_output); endproperty
  a_tog: assert property (p_tog) else $error("no toggle");
  property p_go; pf && en && accumulator_wrap && !act ##1 pf && en |=> act; endproperty
  a_go: assert property (p_go) else $error("pulse late");
  property p_width; pf && en && $fell(act) |-> run == (8'h1 << ctrl.pulse_width_select); endproperty
  a_width: assert property (p_width) else $error("bad pulse width");
  property p_taps; taps == {5{synth_output}}; endproperty
  a_taps: assert property (p_taps) else $error("tap differs");
endmodule : out_props
bind nco_output_stage out_props #(.ACC_WIDTH(ACC_WIDTH)) u_props (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl),
  .increment(increment), .irq_en(irq_en), .flag_clear(flag_clear), .accumulator(accumulator),
  .accumulator_wrap(accumulator_wrap), .overflow_irq_flag(overflow_irq_flag), .irq_request(irq_request),
  .synth_output(synth_output), .taps(taps));
`default_nettype wire

// File: dv/nco_output_stage_tb_top.sv
`default_nettype none
module nco_output_stage_tb_top;
  import nco_out_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_n = 1'b0, fast = 1'b0, slp = 1'b0, clr = 1'b0, was;
  osc_ctrl_t ctrl = '0;
  irq_enables_t irq_en = '0;
  logic [19:0] inc = 20'h0, acc;
  logic wrap, flag, irq, keep, syn;
  consumer_taps_t taps;
  logic [15:0] rises, mark;
  int bad_count = 0, compares = 0;
  always #25 clk_sys = ~clk_sys;
  nco_output_stage #(.ACC_WIDTH(20)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl), .increment(inc),
    .irq_en(irq_en), .fast_osc_selected(fast), .sleep_req(slp), .flag_clear(clr), .accumulator(acc),
    .accumulator_wrap(wrap), .overflow_irq_flag(flag), .irq_request(irq), .keep_fast_osc_on(keep),
    .synth_output(syn), .taps(taps));
  consumer_model partner (.clk_sys(clk_sys), .rst_n(rst_n), .tap(taps.timer_one), .rises(rises));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // width may only change while no pulse is out and acc[19] is set, the accumulator past half way to the next wrap
  task automatic quiet;
    int i;
    i = 0;
    while (!(acc[19] && syn === ctrl.output_polarity_bit) && i < 600) begin
      cyc(1);
      i++;
    end
    if (i == 600) begin
      bad_count++;
      wrap_up;
    end
  endtask : quiet
  initial begin
    cyc(8);
    rst_n = 1'b1;
    chk(acc, 20'h0);
    chk({16'h0, flag, syn, irq, keep}, 20'h0);
    ctrl.module_enable_bit = 1'b1;
    inc = 20'h00003;
    cyc(5);
    chk(acc, 20'h0000f);
    inc = 20'h80000;
    cyc(4);
    chk(flag, 1'b1);
    irq_en = '1;
    cyc(3);
    chk(irq, 1'b1);
    irq_en.global_irq_enable = 1'b0;
    cyc(2);
    chk(irq, 1'b0);
    ctrl.module_enable_bit = 1'b0;
    cyc(20);
    chk(flag, 1'b1);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk(flag, 1'b0);
    inc = 20'h0;
    ctrl.module_enable_bit = 1'b1;
    cyc(2);
    was = syn;
    ctrl.output_polarity_bit = 1'b1;
    cyc(3);
    chk(syn, !was);
    chk(flag, 1'b1);
    slp = 1'b1;
    fast = 1'b1;
    cyc(2);
    chk(keep, 1'b1);
    fast = 1'b0;
    cyc(2);
    chk(keep, 1'b0);
    ctrl.module_enable_bit = 1'b0;
    ctrl.output_polarity_bit = 1'b0;
    cyc(2);
    ctrl.pulse_freq_mode_select = 1'b1;
    ctrl.module_enable_bit = 1'b1;
    inc = 20'h01000;
    for (int k = 0; k < 8; k++) begin
      quiet();
      ctrl.pulse_width_select = k[2:0];
      mark = rises;
      cyc(300);
      chk(rises != mark, 1'b1);
    end
    inc = 20'h08000;
    cyc(300);
    mark = rises;
    cyc(300);
    chk(rises - mark, 20'h0);
    ctrl.pulse_freq_mode_select = 1'b0;
    inc = 20'h10000;
    cyc(16);
    mark = rises;
    cyc(320);
    chk(rises - mark, 20'h0000a);
    wrap_up();
  end
endmodule : nco_output_stage_tb_top
`default_nettype wire
